// >>> design/idb_pkg.sv
// Constants and types shared by the identify parameter block builder.
package idb_pkg;
   localparam logic [7:0]  IDB_CMD_IDENTIFY = 8'hec;
   localparam logic [15:0] IDB_ZERO_WORD    = 16'h0000;
   localparam logic [15:0] IDB_SPACE_PAIR   = 16'h2020;
   localparam logic [15:0] IDB_W1_CYLS      = 16'h3fff;
   localparam logic [15:0] IDB_W2_SPECCFG   = 16'hc837;
   localparam logic [15:0] IDB_W3_HEADS     = 16'h0010;
   localparam logic [15:0] IDB_W6_SPT       = 16'h003f;
   localparam logic [15:0] IDB_W47_MULTMAX  = 16'h8001;
   localparam logic [15:0] IDB_W49_CAP      = 16'h2f00;
   localparam logic [15:0] IDB_W50_CAP      = 16'h4000;
   localparam logic [15:0] IDB_W51_PIO      = 16'h0000;
   localparam logic [15:0] IDB_W53_VALID    = 16'h0007;
   localparam logic [8:0]  IDB_W59_RESET    = 9'h101;
   localparam logic [2:0]  IDB_W63_SUPP     = 3'h7;
   localparam logic [15:0] IDB_W64_PIO      = 16'h0003;
   localparam logic [15:0] IDB_W65_CYCLE    = 16'h0078;
   localparam logic [15:0] IDB_W76_SERCAP   = 16'h0206;
   // Word indices inside the 256-word block.
   localparam logic [7:0]  IDB_WI_SER_LO    = 8'h0a;
   localparam logic [7:0]  IDB_WI_SER_HI    = 8'h13;
   localparam logic [7:0]  IDB_WI_FW_LO     = 8'h17;
   localparam logic [7:0]  IDB_WI_MOD_HI    = 8'h2e;
   localparam logic [7:0]  IDB_WI_FW_SKEW   = 8'h0d;
   localparam logic [8:0]  IDB_WORD_COUNT   = 9'h100;
   localparam int          IDB_STR_WORDS    = 34;
   // Word 63 field positions.
   localparam int          IDB_DMA_SEL_POS  = 8;
   localparam int          IDB_DMA_SUP_POS  = 0;
   // Register byte offsets.
   localparam logic [11:0] IDB_OFF_DMASEL   = 12'h000;
   localparam logic [11:0] IDB_OFF_MULT     = 12'h004;
   localparam logic [11:0] IDB_OFF_CURCYL   = 12'h008;
   localparam logic [11:0] IDB_OFF_CURHS    = 12'h00c;
   localparam logic [11:0] IDB_OFF_CURCAP   = 12'h010;
   localparam logic [11:0] IDB_OFF_TOTSEC   = 12'h014;
   localparam logic [11:0] IDB_OFF_STATUS   = 12'h018;
   localparam logic [11:0] IDB_OFF_STR_LO   = 12'h040;
   localparam logic [11:0] IDB_OFF_STR_HI   = 12'h0c4;
   localparam logic [1:0]  IDB_DMASEL_RST   = 2'h0;
   localparam logic [1:0]  IDB_DMASEL_MAX   = 2'h2;

   typedef struct packed {
      logic [15:0] cyls;
      logic [7:0]  heads;
      logic [15:0] spt;
      logic [31:0] curCap;
      logic [31:0] totSec;
      logic [8:0]  mult;
      logic [1:0]  dmaSel;
   } idb_cfg_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } idb_byte_t;

   typedef enum logic {IDB_IDLE, IDB_SEND} idb_mode_t;
endpackage : idb_pkg

// >>> design/idb_byte_ser.sv
// Splits parameter words into bytes, low byte first.
`timescale 1ns/10ps
`default_nettype none
module idb_byte_ser
   import idb_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        wordValid,
   input  wire logic [15:0] wordData,
   input  wire logic        wordLast,
   output logic             wordReady,
   output idb_byte_t        byteOut,
   input  wire logic        byteReady
);
   typedef struct packed {
      idb_byte_t  out;
      logic [7:0] hiByte;
      logic       hiPending;
      logic       lastPending;
   } idb_ser_t;

   idb_ser_t s_q;
   idb_ser_t s_d;
   logic     slotFree;

   assign slotFree  = !s_q.out.valid || byteReady;
   assign wordReady = slotFree && !s_q.hiPending;
   assign byteOut   = s_q.out;

   always_comb begin
      s_d = s_q;
      if (slotFree) begin
         if (s_q.hiPending) begin
            s_d.out.valid = 1'b1;
            s_d.out.data  = s_q.hiByte;
            s_d.out.last  = s_q.lastPending;
            s_d.hiPending = 1'b0;
         end else if (wordValid) begin
            s_d.out.valid   = 1'b1;
            s_d.out.data    = wordData[7:0];
            s_d.out.last    = 1'b0;
            s_d.hiByte      = wordData[15:8];
            s_d.hiPending   = 1'b1;
            s_d.lastPending = wordLast;
         end else begin
            s_d.out.valid = 1'b0;
            s_d.out.last  = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : idb_byte_ser
`default_nettype wire

// >>> design/idb_identify_builder.sv
// Identify parameter block builder with APB configuration and byte stream out.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module idb_identify_builder
   import idb_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cmdValid,
   input  wire logic [7:0]  cmdCode,
   output logic             cmdBusy,
   output logic             identDone,
   output idb_byte_t        byteOut,
   input  wire logic        byteReady
);
   typedef logic [IDB_STR_WORDS-1:0][15:0] idb_str_t;

   // State of the builder apart from the byte splitter, registered as one word.
   typedef struct packed {
      idb_cfg_t    cfg;
      idb_str_t    str;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      idb_mode_t   mode;
      logic [8:0]  idx;
      logic        wordValid;
      logic [15:0] wordData;
      logic        wordLast;
      logic        done;
      logic        busy;
   } idb_core_t;

   idb_core_t c_q;
   idb_core_t c_d;
   logic      wordReady;
   logic      setupPhase;
   logic      accessWrite;
   logic      addrOk;
   logic [31:0] readVal;

   //////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Merges write data into an old value under the APB byte strobes.
   function automatic logic [31:0] idbMerge(input logic [31:0] oldVal,
                                            input logic [31:0] newVal,
                                            input logic [3:0]  strb);
      logic [31:0] res;
      res = oldVal;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = newVal[b*8 +: 8];
         end
      end
      return res;
   endfunction : idbMerge

   // True for an address inside the string word window.
   function automatic logic idbStrHit(input logic [11:0] addr);
      return (addr >= IDB_OFF_STR_LO) && (addr <= IDB_OFF_STR_HI);
   endfunction : idbStrHit

   // String word number for an address inside the window.
   function automatic logic [5:0] idbStrIdx(input logic [11:0] addr);
      logic [11:0] rel;
      rel = addr - IDB_OFF_STR_LO;
      return rel[7:2];
   endfunction : idbStrIdx

   // One-hot selected DMA mode in word 63, with the supported modes.
   function automatic logic [15:0] idbDmaWord(input logic [1:0] sel);
      logic [15:0] w;
      w = IDB_ZERO_WORD;
      w[IDB_DMA_SUP_POS +: 3] = IDB_W63_SUPP;
      w[IDB_DMA_SEL_POS + 32'(sel)] = 1'b1;
      return w;
   endfunction : idbDmaWord

   // Content of one parameter word.
   function automatic logic [15:0] idbWord(input logic [7:0] wi,
                                           input idb_cfg_t   cfg,
                                           input idb_str_t   str);
      logic [15:0] w;
      logic [7:0]  si;
      w  = IDB_ZERO_WORD;
      si = 8'h00;
      if (wi >= IDB_WI_SER_LO && wi <= IDB_WI_SER_HI) begin
         si = wi - IDB_WI_SER_LO;
         w  = str[si[5:0]];
      end else if (wi >= IDB_WI_FW_LO && wi <= IDB_WI_MOD_HI) begin
         si = wi - IDB_WI_FW_SKEW;
         w  = str[si[5:0]];
      end else begin
         case (wi)
            8'd1:    w = IDB_W1_CYLS;
            8'd2:    w = IDB_W2_SPECCFG;
            8'd3:    w = IDB_W3_HEADS;
            8'd6:    w = IDB_W6_SPT;
            8'd47:   w = IDB_W47_MULTMAX;
            8'd49:   w = IDB_W49_CAP;
            8'd50:   w = IDB_W50_CAP;
            8'd51:   w = IDB_W51_PIO;
            8'd53:   w = IDB_W53_VALID;
            8'd54:   w = cfg.cyls;
            8'd55:   w = {8'h00, cfg.heads};
            8'd56:   w = cfg.spt;
            8'd57:   w = cfg.curCap[15:0];
            8'd58:   w = cfg.curCap[31:16];
            8'd59:   w = {7'h00, cfg.mult};
            8'd60:   w = cfg.totSec[15:0];
            8'd61:   w = cfg.totSec[31:16];
            8'd63:   w = idbDmaWord(cfg.dmaSel);
            8'd64:   w = IDB_W64_PIO;
            8'd65,
            8'd66,
            8'd67,
            8'd68:   w = IDB_W65_CYCLE;
            8'd76:   w = IDB_W76_SERCAP;
            // Reserved, retired and obsolete words, listed so that the map of words 0 to 76 is complete.
            8'd0,
            8'd4,
            8'd5,
            8'd7,
            8'd8,
            8'd9,
            8'd20,
            8'd21,
            8'd22,
            8'd48,
            8'd52,
            8'd62,
            8'd69,
            8'd70,
            8'd71,
            8'd72,
            8'd73,
            8'd74,
            8'd75:   w = IDB_ZERO_WORD;
            default: w = IDB_ZERO_WORD;
         endcase
      end
      return w;
   endfunction : idbWord

   //////////////////////////////////////////////////////////////////////////
   // APB decode.

   // A setup is taken only while no answer is pending, so one transfer is never seen twice.
   assign setupPhase  = psel && !penable && !c_q.pready;
   assign accessWrite = psel && penable && c_q.pready && pwrite && !c_q.pslverr;

   // Read value and address check for the current setup cycle.
   always_comb begin
      readVal = 32'h0000_0000;
      addrOk  = (paddr[1:0] == 2'b00);
      if (idbStrHit(paddr)) begin
         readVal = {16'h0000, c_q.str[idbStrIdx(paddr)]};
      end else begin
         case (paddr)
            IDB_OFF_DMASEL: readVal = {30'h0, c_q.cfg.dmaSel};
            IDB_OFF_MULT:   readVal = {23'h0, c_q.cfg.mult};
            IDB_OFF_CURCYL: readVal = {16'h0, c_q.cfg.cyls};
            IDB_OFF_CURHS:  readVal = {c_q.cfg.spt, 8'h00, c_q.cfg.heads};
            IDB_OFF_CURCAP: readVal = c_q.cfg.curCap;
            IDB_OFF_TOTSEC: readVal = c_q.cfg.totSec;
            IDB_OFF_STATUS: readVal = {23'h0, c_q.idx[7:0], (c_q.mode == IDB_SEND)};
            default:        addrOk  = 1'b0;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      logic [31:0] m;
      m   = 32'h0000_0000;
      c_d = c_q;
      // The done strobe lasts one cycle unless it is set again below.
      c_d.done = 1'b0;

      // Answer comes in the cycle after setup, with data captured at setup.
      c_d.pready = setupPhase;
      if (setupPhase) begin
         c_d.prdata  = (addrOk && !pwrite) ? readVal : 32'h0000_0000;
         c_d.pslverr = !addrOk;
      end else begin
         // Read data and error stand only for the access cycle and read zero otherwise.
         c_d.prdata  = 32'h0000_0000;
         c_d.pslverr = 1'b0;
      end

      // Writes land at the access edge; refused accesses change nothing.
      if (accessWrite) begin
         if (idbStrHit(paddr)) begin
            m = idbMerge({16'h0000, c_q.str[idbStrIdx(paddr)]}, pwdata, pstrb);
            c_d.str[idbStrIdx(paddr)] = m[15:0];
         end else begin
            // Register writes; unmapped offsets were already refused at setup.
            case (paddr)
               IDB_OFF_DMASEL: begin
                  m = idbMerge({30'h0, c_q.cfg.dmaSel}, pwdata, pstrb);
                  // Mode 3 does not exist; keep the old one-hot selection.
                  if (m[1:0] <= IDB_DMASEL_MAX) begin
                     c_d.cfg.dmaSel = m[1:0];
                  end
               end
               IDB_OFF_MULT: begin
                  m = idbMerge({23'h0, c_q.cfg.mult}, pwdata, pstrb);
                  c_d.cfg.mult = m[8:0];
               end
               IDB_OFF_CURCYL: begin
                  m = idbMerge({16'h0, c_q.cfg.cyls}, pwdata, pstrb);
                  c_d.cfg.cyls = m[15:0];
               end
               IDB_OFF_CURHS: begin
                  m = idbMerge({c_q.cfg.spt, 8'h00, c_q.cfg.heads}, pwdata, pstrb);
                  c_d.cfg.heads = m[7:0];
                  c_d.cfg.spt   = m[31:16];
               end
               IDB_OFF_CURCAP: begin
                  c_d.cfg.curCap = idbMerge(c_q.cfg.curCap, pwdata, pstrb);
               end
               IDB_OFF_TOTSEC: begin
                  c_d.cfg.totSec = idbMerge(c_q.cfg.totSec, pwdata, pstrb);
               end
               default: begin
               end
            endcase
         end
      end

      // Word sequencer feeding the byte splitter.
      // Words are built live, so a register write during a block shows in later words.
      case (c_q.mode)
         IDB_IDLE: begin
            // Only an idle builder takes a command, so one sent during a block is dropped.
            if (cmdValid && cmdCode == IDB_CMD_IDENTIFY) begin
               c_d.mode      = IDB_SEND;
               c_d.busy      = 1'b1;
               c_d.idx       = 9'h000;
               c_d.wordValid = 1'b0;
               c_d.wordLast  = 1'b0;
            end
         end
         IDB_SEND: begin
            // Hand one word to the splitter each time it can take one.
            if (!c_q.wordValid || wordReady) begin
               if (c_q.idx < IDB_WORD_COUNT) begin
                  c_d.wordValid = 1'b1;
                  c_d.wordData  = idbWord(c_q.idx[7:0], c_q.cfg, c_q.str);
                  c_d.wordLast  = (c_q.idx == IDB_WORD_COUNT - 9'h001);
                  c_d.idx       = c_q.idx + 9'h001;
               end else begin
                  c_d.wordValid = 1'b0;
                  c_d.wordLast  = 1'b0;
                  // The last word is handed over; the splitter may still hold two bytes.
                  c_d.mode      = IDB_IDLE;
                  c_d.busy      = 1'b0;
                  c_d.done      = 1'b1;
               end
            end
         end
         default: begin
            c_d.mode = IDB_IDLE;
            c_d.busy = 1'b0;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         c_q             <= '0;
         c_q.cfg.mult    <= IDB_W59_RESET;
         c_q.cfg.dmaSel  <= IDB_DMASEL_RST;
         c_q.mode        <= IDB_IDLE;
         // Strings reset to spaces so that unwritten positions are already padded.
         for (int i = 0; i < IDB_STR_WORDS; i++) begin
            c_q.str[i] <= IDB_SPACE_PAIR;
         end
      end else begin
         c_q <= c_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Byte splitter and outputs.

   // The splitter holds each byte until the host takes it.
   idb_byte_ser u_ser (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .wordValid (c_q.wordValid),
      .wordData  (c_q.wordData),
      .wordLast  (c_q.wordLast),
      .wordReady (wordReady),
      .byteOut   (byteOut),
      .byteReady (byteReady)
   );

   // Every output is taken straight from a register.
   assign prdata    = c_q.prdata;
   assign pready    = c_q.pready;
   assign pslverr   = c_q.pslverr;
   assign cmdBusy   = c_q.busy;
   assign identDone = c_q.done;
endmodule : idb_identify_builder
`default_nettype wire

// >>> verif/idb_checker.sv
// Port-level assertions for the identify parameter block builder.
`timescale 1ns/10ps
`default_nettype none
module idb_checker
   import idb_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cmdValid,
   input wire logic [7:0]  cmdCode,
   input wire logic        cmdBusy,
   input wire logic        identDone,
   input wire idb_byte_t   byteOut,
   input wire logic        byteReady
);
   logic [8:0] sentCnt_q;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // Counts bytes taken by the host so that the block boundary is known.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sentCnt_q <= 9'h000;
      end else if (byteOut.valid && byteReady) begin
         sentCnt_q <= sentCnt_q + 9'h001;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
      else $error("no ready in the access cycle");
   AST_PREADY_ONLY: assert property (pready |-> psel && penable)
      else $error("ready outside an access cycle");
   AST_MISALIGN_ERR: assert property (psel && !penable && paddr[1:0] != 2'h0 |=>
      pslverr && prdata == 32'h0) else $error("misaligned access not refused");
   AST_TAKE_START: assert property (cmdValid && cmdCode == 8'hec && !cmdBusy |=>
      cmdBusy ##2 byteOut.valid) else $error("identify command not started");
   AST_OTHER_CODE: assert property (cmdValid && cmdCode != 8'hec && !cmdBusy |=> !cmdBusy)
      else $error("other command code started a block");
   AST_BYTE_HOLD: assert property (byteOut.valid && !byteReady |=> byteOut.valid &&
      $stable(byteOut.data) && $stable(byteOut.last)) else $error("byte changed while held");
   AST_LAST_POS: assert property (byteOut.valid |-> byteOut.last == (sentCnt_q == 9'h1ff))
      else $error("last flag not on byte 512");
   AST_DONE_PULSE: assert property (identDone |=> !identDone)
      else $error("done longer than one cycle");
   AST_BUSY_END: assert property ($fell(cmdBusy) |-> identDone)
      else $error("busy fell without done");

   COV_DONE: cover property (identDone);
   COV_STALL: cover property (byteOut.valid && !byteReady);
   COV_ERR: cover property (pslverr);
   COV_DROP: cover property (cmdValid && cmdBusy);
endmodule : idb_checker

bind idb_identify_builder idb_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdBusy(cmdBusy), .identDone(identDone),
   .byteOut(byteOut), .byteReady(byteReady));
`default_nettype wire

// >>> verif/idb_host_model.sv
// Host stand-in that takes the byte stream and rebuilds the parameter words.
`timescale 1ns/10ps
`default_nettype none
module idb_host_model
   import idb_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      sys_rst,
   input  wire logic      slow,
   input  wire idb_byte_t byteOut,
   output logic           byteReady
);
   logic [15:0] words [$];
   int          nBytes = 0;
   int          lastAt = -1;
   logic [7:0]  lowByte;
   logic [1:0]  phase = 2'h0;

   // Slow mode takes one byte in four cycles so the device must hold its byte.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         byteReady <= 1'b0;
      end else begin
         if (byteOut.valid === 1'b1 && byteReady === 1'b1) begin
            if (byteOut.last === 1'b1) lastAt = nBytes;
            if (nBytes % 2 == 1) words.push_back({byteOut.data, lowByte});
            else lowByte = byteOut.data;
            nBytes++;
         end
         phase <= phase + 2'h1;
         byteReady <= !slow || phase == 2'h3;
      end
   end
endmodule : idb_host_model
`default_nettype wire

// >>> verif/idb_identify_builder_tb_top.sv
// Self-checking bench: APB setup, identify block capture and word compare.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin n_fail++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module idb_identify_builder_tb_top import idb_pkg::*; ;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic        cmdValid = 1'b0;
   logic [7:0]  cmdCode = 8'h00;
   logic        slow = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, cmdBusy, identDone, byteReady;
   idb_byte_t   byteOut;
   int          n_fail = 0;
   int          checked = 0;
   logic [31:0] seed = 32'ha79950d9;
   logic [15:0] strW [34];
   logic [15:0] refW [256];
   logic [31:0] curCyl, curHs, curCap, totSec;
   logic [8:0]  mult;
   int          dma;
   int          fixIdx [14] = '{1, 2, 3, 6, 47, 49, 50, 53, 64, 65, 66, 67, 68, 76};
   logic [15:0] fixVal [14] = '{16'h3fff, 16'hc837, 16'h0010, 16'h003f, 16'h8001, 16'h2f00,
      16'h4000, 16'h0007, 16'h0003, 16'h0078, 16'h0078, 16'h0078, 16'h0078, 16'h0206};

   always #12.5 clk_sys = ~clk_sys;

   idb_identify_builder uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmdValid(cmdValid),
      .cmdCode(cmdCode), .cmdBusy(cmdBusy), .identDone(identDone), .byteOut(byteOut),
      .byteReady(byteReady));
   idb_host_model host (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
      .byteOut(byteOut), .byteReady(byteReady));

   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xorshift

   task print_verdict();
      $display("checked %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   task hang();
      n_fail++;
      $display("mismatch timeout exp done got hang");
      print_verdict();
   endtask : hang

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [31:0] rd, output logic err);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      if (k == 16) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so that a following call never drives psel again in this step.
      @(posedge clk_sys);
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, s, r, e);
   endtask : wr

   // Reference block built from the documented word layout and the current settings.
   function void buildRef();
      foreach (refW[i]) refW[i] = 16'h0000;
      foreach (fixIdx[j]) refW[fixIdx[j]] = fixVal[j];
      foreach (strW[i]) refW[i < 10 ? 10 + i : 13 + i] = strW[i];
      refW[54] = curCyl[15:0];
      refW[55] = {8'h00, curHs[7:0]};
      refW[56] = curHs[31:16];
      refW[57] = curCap[15:0];
      refW[58] = curCap[31:16];
      refW[59] = {7'h00, mult};
      refW[60] = totSec[15:0];
      refW[61] = totSec[31:16];
      refW[63] = 16'h0007 | (16'h0100 << dma);
   endfunction : buildRef

   task runIdent();
      int          k;
      logic [15:0] got;
      string       nm;
      logic [31:0] sd;
      logic        se;
      host.words.delete();
      host.nBytes = 0;
      host.lastAt = -1;
      buildRef();
      cmdValid <= 1'b1;
      cmdCode <= 8'hec;
      @(posedge clk_sys);
      cmdValid <= 1'b0;
      apb(1'b0, IDB_OFF_STATUS, 32'h0, 4'hf, sd, se);
      `CHK("status_busy", 1'b1, sd[0])
      for (k = 0; k < 4000 && host.words.size() < 256; k++) begin
         @(posedge clk_sys);
         cmdValid <= (k == 40);
      end
      if (k == 4000) hang();
      repeat (40) @(posedge clk_sys);
      `CHK("bytes", 512, host.nBytes)
      `CHK("last", 511, host.lastAt)
      `CHK("busy", 1'b0, cmdBusy)
      foreach (refW[i]) begin
         got = host.words[i];
         nm = $sformatf("word %0d", i);
         if (i >= 64) `CHK(nm, refW[i], got)
         else if (i >= 54) `CHK(nm, refW[i], got)
         else if (i >= 10 && i <= 46) `CHK(nm, refW[i], got)
         else `CHK(nm, refW[i], got)
      end
   endtask : runIdent

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic        e;
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      foreach (strW[i]) strW[i] = 16'h2020;
      {curCyl, curHs, curCap, totSec} = 128'h0;
      mult = 9'h101;
      dma = 0;
      apb(1'b0, IDB_OFF_MULT, 32'h0, 4'hf, d, e);
      `CHK("mult", 32'h0000_0101, d)
      apb(1'b1, 12'h005, 32'h0, 4'hf, d, e);
      `CHK("misaligned", 1'b1, e)
      apb(1'b0, 12'h030, 32'h0, 4'hf, d, e);
      `CHK("unmapped", 1'b1, e)
      runIdent();
      $display("test reset_block done");
      foreach (strW[i]) begin
         d = xorshift();
         strW[i] = {8'h20 + 8'(d[7:0] % 95), 8'h20 + 8'(d[15:8] % 95)};
         wr(IDB_OFF_STR_LO + 12'(4 * i), {16'h0, strW[i]}, 4'hf);
      end
      curCyl = xorshift();
      wr(IDB_OFF_CURCYL, curCyl, 4'hf);
      curHs = xorshift();
      wr(IDB_OFF_CURHS, curHs, 4'hf);
      curCap = xorshift();
      wr(IDB_OFF_CURCAP, curCap, 4'hf);
      totSec = xorshift();
      wr(IDB_OFF_TOTSEC, totSec, 4'hf);
      d = xorshift();
      wr(IDB_OFF_MULT, d, 4'h1);
      mult = {mult[8], d[7:0]};
      for (int v = 0; v < 4; v++) begin
         wr(IDB_OFF_DMASEL, 32'(v), 4'hf);
         if (v < 3) dma = v;
         slow <= v[0];
         runIdent();
         $display("test dma_mode %0d done", v);
      end
      cmdValid <= 1'b1;
      cmdCode <= 8'h90;
      @(posedge clk_sys);
      cmdValid <= 1'b0;
      repeat (4) @(posedge clk_sys);
      `CHK("busy_other_code", 1'b0, cmdBusy)
      $display("test other_code done");
      print_verdict();
   end
endmodule : idb_identify_builder_tb_top
`default_nettype wire
